// ### include/sst_pkg.sv
/*
  sst_pkg: register offsets, field positions, reset values and clock-source
  codes for the serial status and average-rate clock block.
  assumes: byte-wide registers reached by a plain address/strobe port.
*/
package sst_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [27:0] SERIAL_MODE_OFF     = 28'h0fff600;
  localparam logic [27:0] SERIAL_CONTROL_OFF  = 28'h0fff602;
  localparam logic [27:0] SERIAL_STATUS_OFF   = 28'h0fff604;
  localparam logic [27:0] SMARTCARD_MODE_OFF  = 28'hffff606;
  localparam logic [27:0] EXPANSION_MODE_OFF  = 28'hffff608;
  localparam logic [27:0] TX_HOLDING_OFF      = 28'h0fff603;
  localparam logic [27:0] RX_HOLDING_OFF      = 28'h0fff605;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_EMPTY_BIT   = 7;
  localparam int RX_FULL_BIT    = 6;
  localparam int OVERRUN_BIT    = 5;
  localparam int FRAMING_BIT    = 4;
  localparam int PARITY_BIT     = 3;
  localparam int TX_DONE_BIT    = 2;
  localparam int SMARTCARD_BIT  = 0;
  localparam int DIV_SELECT_BIT = 4;
  localparam int MODE_SYNC_BIT  = 7;
  localparam int TX_ENABLE_BIT  = 5;
  localparam int RX_ENABLE_BIT  = 4;
  localparam int EXT_CLOCK_BIT  = 1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET    = 8'h84;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam logic [7:0] SMARTCARD_RESET = 8'h00;
  localparam logic [7:0] EXPANSION_RESET = 8'h00;
  // ----------------------------------------------------------------
  // clock source codes and dividers
  // ----------------------------------------------------------------
  localparam logic [3:0] ACS_NONE    = 4'h0;
  localparam logic [3:0] ACS_TIMER   = 4'h4;
  localparam logic [3:0] ACS_LAST    = 4'hc;
  localparam logic [4:0] DIV_SIXTEEN = 5'h10;
  localparam logic [4:0] DIV_EIGHT   = 5'h08;
  typedef enum logic [1:0] {SST_SRC_INTERNAL, SST_SRC_EXT_PLAIN, SST_SRC_TIMER, SST_SRC_AVERAGE} sst_src_e;
endpackage

// ### design/sst_top.sv
/*
  sst_top: status flags of one asynchronous serial channel and the
  selection of its clock source and base-clock divider.
  assumes: the serial engine reports events as one-cycle pulses on the
  peripheral clock; the far serial port runs its own framing.
*/
// Chosen here: the address-and-strobe port.
// Summary of operation
// - tx empty sets on disable or load
// - tx empty clears by zero write or dma
// - rx full sets on any reception while clear, errors included
// - rx full clears by zero write or dma
// - rx disable leaves rx full alone
// - reception while full: overrun, drop byte
// - overrun sets on overrun, zero-write clear
// - framing, parity set on error, zero-write clear
// - tx done sets on disable, or on last bit while tx empty is set
// - tx done clears with tx empty clear
// - written zeros clear, written ones ignored
// - smartcard select picks smartcard operation
// - divider select gives 16 or 8
// - code 0011 average rate, divide by 8
// - code 0000 bypasses average generator
// - code 0100 uses timer compare match
// - average code sets divider, ignores select
// - code acts only async with external clock
// - codes 0001 and 0010 defined dividers
// - codes 0101 and 0110 divide by 16
// - codes 0111 to 1100 defined dividers
// - clock field upper bit picks external source
// - mode bit picks async or synchronous
`timescale 1ns/1ps
module sst_top
(
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic [27:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_tx_load,
  input  wire logic        i_tx_last_bit,
  input  wire logic        i_rx_done,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_framing_err,
  input  wire logic        i_rx_parity_err,
  input  wire logic        i_dma_tx_write,
  input  wire logic [7:0]  i_dma_tx_data,
  input  wire logic        i_dma_rx_read,
  output logic             o_tx_empty_request,
  output logic             o_rx_full_request,
  output logic      [7:0]  o_tx_holding,
  output logic             o_smartcard_mode,
  output logic             o_sync_mode,
  output logic      [1:0]  o_clock_source,
  output logic      [4:0]  o_base_divider,
  output logic      [3:0]  o_avg_code
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] smartcard_reg;
  logic [7:0] smartcard_next;
  logic [7:0] expansion_reg;
  logic [7:0] expansion_next;
  logic [7:0] tx_holding_reg;
  logic [7:0] tx_holding_next;
  logic [7:0] rx_holding_reg;
  logic [7:0] rx_holding_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] seen_one_reg;
  logic [7:0] seen_one_next;

  // ----------------------------------------------------------------
  // strobes decoded from the register port and the receive pulse
  // ----------------------------------------------------------------
  logic       wr_status;
  logic       wr_control;
  logic       wr_mode;
  logic       wr_smartcard;
  logic       wr_expansion;
  logic       wr_tx;
  logic       rd_status;
  logic       tx_disable;
  logic       rx_store;
  logic       overrun;
  logic [7:0] clr;

  always_comb
  begin
    wr_status    = 1'b0;
    wr_control   = 1'b0;
    wr_mode      = 1'b0;
    wr_smartcard = 1'b0;
    wr_expansion = 1'b0;
    wr_tx        = 1'b0;
    if (i_wr && (i_addr == sst_pkg::SERIAL_STATUS_OFF))
      wr_status = 1'b1;
    else if (i_wr && (i_addr == sst_pkg::SERIAL_CONTROL_OFF))
      wr_control = 1'b1;
    else if (i_wr && (i_addr == sst_pkg::SERIAL_MODE_OFF))
      wr_mode = 1'b1;
    else if (i_wr && (i_addr == sst_pkg::SMARTCARD_MODE_OFF))
      wr_smartcard = 1'b1;
    else if (i_wr && (i_addr == sst_pkg::EXPANSION_MODE_OFF))
      wr_expansion = 1'b1;
    else if (i_wr && (i_addr == sst_pkg::TX_HOLDING_OFF))
      wr_tx = 1'b1;
    rd_status  = i_rd && (i_addr == sst_pkg::SERIAL_STATUS_OFF);
    // only a 1 to 0 change of the enable counts as disabling
    tx_disable = wr_control && control_reg[sst_pkg::TX_ENABLE_BIT] && !i_wdata[sst_pkg::TX_ENABLE_BIT];
    // a zero clears only after the bit was read as one; ones are ignored
    clr = wr_status ? (~i_wdata & seen_one_reg & status_reg) : 8'h00;
    overrun  = i_rx_done && status_reg[sst_pkg::RX_FULL_BIT];
    rx_store = i_rx_done && !status_reg[sst_pkg::RX_FULL_BIT];
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb
  begin
    status_next = status_reg;
    // tx empty: clear first, set wins so no load event is lost
    if (clr[sst_pkg::TX_EMPTY_BIT] || i_dma_tx_write)
    begin
      status_next[sst_pkg::TX_EMPTY_BIT] = 1'b0;
      status_next[sst_pkg::TX_DONE_BIT]  = 1'b0;
    end
    if (tx_disable || i_tx_load)
    begin
      status_next[sst_pkg::TX_EMPTY_BIT] = 1'b1;
    end
    if (tx_disable || (i_tx_last_bit && status_reg[sst_pkg::TX_EMPTY_BIT]))
    begin
      status_next[sst_pkg::TX_DONE_BIT] = 1'b1;
    end
    // rx enable is not looked at here, so disabling keeps the flag
    if (clr[sst_pkg::RX_FULL_BIT] || i_dma_rx_read)
    begin
      status_next[sst_pkg::RX_FULL_BIT] = 1'b0;
    end
    if (rx_store)
    begin
      status_next[sst_pkg::RX_FULL_BIT] = 1'b1;
    end
    if (clr[sst_pkg::OVERRUN_BIT])
    begin
      status_next[sst_pkg::OVERRUN_BIT] = 1'b0;
    end
    if (overrun)
    begin
      status_next[sst_pkg::OVERRUN_BIT] = 1'b1;
    end
    if (clr[sst_pkg::FRAMING_BIT])
    begin
      status_next[sst_pkg::FRAMING_BIT] = 1'b0;
    end
    if (i_rx_done && i_rx_framing_err)
    begin
      status_next[sst_pkg::FRAMING_BIT] = 1'b1;
    end
    if (clr[sst_pkg::PARITY_BIT])
    begin
      status_next[sst_pkg::PARITY_BIT] = 1'b0;
    end
    if (i_rx_done && i_rx_parity_err)
    begin
      status_next[sst_pkg::PARITY_BIT] = 1'b1;
    end
    status_next[1:0] = 2'h0;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status_reg <= sst_pkg::STATUS_RESET;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // control and mode registers
  // ----------------------------------------------------------------
  always_comb
  begin
    control_next   = control_reg;
    mode_next      = mode_reg;
    smartcard_next = smartcard_reg;
    expansion_next = expansion_reg;
    if (wr_control)
    begin
      control_next = i_wdata;
    end
    if (wr_mode)
    begin
      mode_next = i_wdata;
    end
    if (wr_smartcard)
    begin
      smartcard_next = i_wdata;
    end
    if (wr_expansion)
    begin
      expansion_next = i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      control_reg   <= sst_pkg::CONTROL_RESET;
      mode_reg      <= sst_pkg::MODE_RESET;
      smartcard_reg <= sst_pkg::SMARTCARD_RESET;
      expansion_reg <= sst_pkg::EXPANSION_RESET;
    end
    else
    begin
      control_reg   <= control_next;
      mode_reg      <= mode_next;
      smartcard_reg <= smartcard_next;
      expansion_reg <= expansion_next;
    end
  end

  // ----------------------------------------------------------------
  // holding registers
  // ----------------------------------------------------------------
  always_comb
  begin
    tx_holding_next = tx_holding_reg;
    rx_holding_next = rx_holding_reg;
    // the dma write wins over a software write in the same cycle
    if (i_dma_tx_write)
    begin
      tx_holding_next = i_dma_tx_data;
    end
    else if (wr_tx)
    begin
      tx_holding_next = i_wdata;
    end
    // an overrun byte is dropped, the old byte stays readable
    if (rx_store)
    begin
      rx_holding_next = i_rx_byte;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx_holding_reg <= 8'h00;
      rx_holding_reg <= 8'h00;
    end
    else
    begin
      tx_holding_reg <= tx_holding_next;
      rx_holding_reg <= rx_holding_next;
    end
  end

  // ----------------------------------------------------------------
  // read port and read-as-one memory
  // ----------------------------------------------------------------
  always_comb
  begin
    seen_one_next = seen_one_reg;
    // a status write uses up what the last read showed, unless a status read in the same cycle reloads it
    if (wr_status)
    begin
      seen_one_next = 8'h00;
    end
    if (rd_status)
    begin
      seen_one_next = status_reg;
    end
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_status)
    begin
      rdata_next = status_reg;
    end
    else if (i_rd && (i_addr == sst_pkg::SERIAL_CONTROL_OFF))
    begin
      rdata_next = control_reg;
    end
    else if (i_rd && (i_addr == sst_pkg::SERIAL_MODE_OFF))
    begin
      rdata_next = mode_reg;
    end
    else if (i_rd && (i_addr == sst_pkg::SMARTCARD_MODE_OFF))
    begin
      rdata_next = smartcard_reg;
    end
    else if (i_rd && (i_addr == sst_pkg::EXPANSION_MODE_OFF))
    begin
      rdata_next = {3'h0, expansion_reg[4:0]};
    end
    else if (i_rd && (i_addr == sst_pkg::TX_HOLDING_OFF))
    begin
      rdata_next = tx_holding_reg;
    end
    else if (i_rd && (i_addr == sst_pkg::RX_HOLDING_OFF))
    begin
      rdata_next = rx_holding_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_reg    <= 8'h00;
      seen_one_reg <= 8'h00;
    end
    else
    begin
      rdata_reg    <= rdata_next;
      seen_one_reg <= seen_one_next;
    end
  end

  // ----------------------------------------------------------------
  // clock source and divider
  // ----------------------------------------------------------------
  logic       async_ext;
  logic [3:0] code;
  always_comb
  begin
    code = expansion_reg[3:0];
    async_ext = !mode_reg[sst_pkg::MODE_SYNC_BIT] && control_reg[sst_pkg::EXT_CLOCK_BIT];
    o_base_divider = expansion_reg[sst_pkg::DIV_SELECT_BIT] ? sst_pkg::DIV_EIGHT : sst_pkg::DIV_SIXTEEN;
    o_avg_code = 4'h0;
    if (!control_reg[sst_pkg::EXT_CLOCK_BIT])
      o_clock_source = sst_pkg::SST_SRC_INTERNAL;
    else if (!async_ext || code == sst_pkg::ACS_NONE || code > sst_pkg::ACS_LAST)
      o_clock_source = sst_pkg::SST_SRC_EXT_PLAIN;
    else if (code == sst_pkg::ACS_TIMER)
      o_clock_source = sst_pkg::SST_SRC_TIMER;
    else
    begin
      o_clock_source = sst_pkg::SST_SRC_AVERAGE;
      o_avg_code = code;
      case (code)
        4'h2, 4'h3, 4'h7, 4'ha, 4'hb: o_base_divider = sst_pkg::DIV_EIGHT;
        default:                      o_base_divider = sst_pkg::DIV_SIXTEEN;
      endcase
    end
  end

  assign o_rdata            = rdata_reg;
  assign o_tx_holding       = tx_holding_reg;
  assign o_tx_empty_request = status_reg[sst_pkg::TX_EMPTY_BIT] && control_reg[sst_pkg::TX_ENABLE_BIT];
  assign o_rx_full_request  = status_reg[sst_pkg::RX_FULL_BIT];
  assign o_smartcard_mode   = smartcard_reg[sst_pkg::SMARTCARD_BIT];
  assign o_sync_mode        = mode_reg[sst_pkg::MODE_SYNC_BIT];
endmodule

// ### dv/sst_chk_asserts.sv
/* sst_chk: port-level assertions on the status flags and clock selection.
   assumes: bound to sst_top; one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
module sst_chk
(
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic [27:0] i_addr,
  input wire logic        i_rd,
  input wire logic        i_rx_done,
  input wire logic        i_rx_framing_err,
  input wire logic        i_rx_parity_err,
  input wire logic        i_dma_rx_read,
  input wire logic        i_dma_tx_write,
  input wire logic        i_tx_load,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_tx_empty_request,
  input wire logic        o_rx_full_request,
  input wire logic [1:0]  o_clock_source,
  input wire logic [4:0]  o_base_divider,
  input wire logic [3:0]  o_avg_code
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  full_read_a: assert property (
    i_rd && i_addr == sst_pkg::SERIAL_STATUS_OFF |=> o_rdata[6] == $past(o_rx_full_request)) else $error("full bit");
  rx_set_a: assert property (
    i_rx_done && !i_rx_framing_err && !i_rx_parity_err |=> o_rx_full_request) else $error("full not set");
  rx_clear_a: assert property (
    i_dma_rx_read && !i_rx_done |=> !o_rx_full_request) else $error("full not cleared");
  tx_clear_a: assert property (
    o_tx_empty_request && i_dma_tx_write && !i_tx_load |=> !o_tx_empty_request) else $error("empty not cleared");
  div_eight_a: assert property (
    o_clock_source == 2'h3 && o_avg_code inside {4'h2, 4'h3, 4'h7, 4'ha, 4'hb} |-> o_base_divider == 5'h08)
    else $error("divider not 8");
  div_sixteen_a: assert property (
    o_clock_source == 2'h3 && o_avg_code inside {4'h1, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc} |-> o_base_divider == 5'h10)
    else $error("divider not 16");
  code_idle_a: assert property (
    o_clock_source != 2'h3 |-> o_avg_code == 4'h0) else $error("code without average source");
  code_legal_a: assert property (
    o_clock_source == 2'h3 |-> o_avg_code inside {[4'h1:4'h3], [4'h5:4'hc]}) else $error("undefined code used");
endmodule
bind sst_top sst_chk sst_chk_i (.*);

// ### dv/sst_far.sv
/* sst_far: serial engine and far port, one-cycle event pulses.
   assumes: tasks are entered just after a rising clock edge. */
`timescale 1ns/1ps
module sst_far
(
  input  wire logic       i_core_clk,
  output logic            o_rx_done,
  output logic      [7:0] o_rx_byte,
  output logic            o_framing_err,
  output logic            o_parity_err,
  output logic            o_tx_load,
  output logic            o_tx_last_bit
);
  initial
  begin
    {o_rx_done, o_framing_err, o_parity_err, o_tx_load, o_tx_last_bit} = '0;
    o_rx_byte = 8'h5a;
  end
  task automatic frame(input logic [7:0] b, input logic fe, input logic pe);
    o_rx_byte <= b;
    o_framing_err <= fe;
    o_parity_err <= pe;
    o_rx_done <= 1'b1;
    @(posedge i_core_clk);
    {o_rx_done, o_framing_err, o_parity_err} <= 3'h0;
    // stale byte lines must never look like the last byte
    o_rx_byte <= ~b;
    #1;
  endtask
  task automatic tx(input logic last);
    o_tx_load <= !last;
    o_tx_last_bit <= last;
    @(posedge i_core_clk);
    {o_tx_load, o_tx_last_bit} <= 2'h0;
    #1;
  endtask
endmodule

// ### dv/tb_top.sv
/* tb_top: self-checking bench for sst_top with an integer flag model.
   assumes: sst_far stands in for the serial engine. */
`timescale 1ns/1ps
module tb_top;
  logic        i_core_clk, i_nrst, i_wr, i_rd, i_rx_done, i_rx_framing_err, i_rx_parity_err;
  logic        i_tx_load, i_tx_last_bit, i_dma_tx_write, i_dma_rx_read;
  logic        o_tx_empty_request, o_rx_full_request, o_smartcard_mode, o_sync_mode;
  logic [27:0] i_addr;
  logic [7:0]  i_wdata, i_rx_byte, i_dma_tx_data, o_rdata, o_tx_holding, got;
  logic [1:0]  o_clock_source;
  logic [4:0]  o_base_divider;
  logic [3:0]  o_avg_code;
  int          n_fail, comparisons, exp_st, seen, b, k, a8;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
  sst_top sst_top_i (.*);
  sst_far sst_far_i (.i_core_clk(i_core_clk), .o_rx_done(i_rx_done), .o_rx_byte(i_rx_byte),
    .o_framing_err(i_rx_framing_err), .o_parity_err(i_rx_parity_err), .o_tx_load(i_tx_load),
    .o_tx_last_bit(i_tx_last_bit));
  task automatic wr(input logic [27:0] a, input logic [7:0] d);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [27:0] a);
    {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask
  task automatic st();
    rd(sst_pkg::SERIAL_STATUS_OFF);
    seen = int'(got);
  endtask
  // zeros clear only what the last status read showed as one
  task automatic clr(input logic [7:0] w);
    int c;
    c = seen & ~int'(w) & 'hf8;
    if (c[7]) c = c | 4;
    exp_st = exp_st & ~c;
    wr(sst_pkg::SERIAL_STATUS_OFF, w);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_core_clk);
    n_fail++;
    wrap_up();
  end
  initial
  begin
    {i_nrst, i_wr, i_rd, i_dma_tx_write, i_dma_rx_read, i_addr, i_wdata, i_dma_tx_data} = '0;
    {n_fail, comparisons, exp_st} = {32'h0, 32'h0, 32'h84};
    b = $urandom(32'h1dcc58cb);
    repeat (6) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(posedge i_core_clk);
    st();
    `CHK(got, 8'h84)
    b = $urandom;
    sst_far_i.frame(b[7:0], 1'b0, 1'b0);
    sst_far_i.frame(~b[7:0], 1'b0, 1'b0);
    exp_st = exp_st | 'h60;
    rd(sst_pkg::RX_HOLDING_OFF);
    `CHK(got, b[7:0])
    st();
    `CHK(got, exp_st[7:0])
    wr(sst_pkg::SERIAL_STATUS_OFF, 8'hff);
    st();
    `CHK(got, exp_st[7:0])
    clr(8'h80);
    st();
    `CHK(got, exp_st[7:0])
    sst_far_i.frame(b[7:0], 1'b1, 1'b1);
    st();
    `CHK(got & 8'h38, 8'h18)
    clr(8'h80);
    wr(sst_pkg::SERIAL_CONTROL_OFF, 8'h10);
    sst_far_i.frame(b[7:0], 1'b0, 1'b0);
    exp_st = exp_st | 'h40;
    wr(sst_pkg::SERIAL_CONTROL_OFF, 8'h00);
    st();
    `CHK(got, exp_st[7:0])
    i_dma_rx_read <= 1'b1;
    @(posedge i_core_clk);
    i_dma_rx_read <= 1'b0;
    exp_st = 'h84;
    st();
    `CHK(got, exp_st[7:0])
    $display("test receive flags done");
    repeat (16) @(posedge i_core_clk);
    wr(sst_pkg::SERIAL_CONTROL_OFF, 8'h20);
    `CHK(o_tx_empty_request, 1'b1)
    {i_dma_tx_data, i_dma_tx_write} <= {b[7:0], 1'b1};
    @(posedge i_core_clk);
    i_dma_tx_write <= 1'b0;
    exp_st = 0;
    st();
    `CHK(got, exp_st[7:0])
    `CHK(o_tx_holding, b[7:0])
    sst_far_i.tx(1'b0);
    exp_st = 'h80;
    st();
    `CHK(got, exp_st[7:0])
    sst_far_i.tx(1'b1);
    exp_st = 'h84;
    st();
    `CHK(got, exp_st[7:0])
    clr(8'h00);
    st();
    `CHK(got, exp_st[7:0])
    wr(sst_pkg::SERIAL_CONTROL_OFF, 8'h02);
    st();
    `CHK(got, 8'h84)
    $display("test transmit flags done");
    wr(sst_pkg::SMARTCARD_MODE_OFF, 8'h01);
    `CHK(o_smartcard_mode, 1'b1)
    for (k = 0; k < 16; k++)
    begin
      a8 = $urandom % 2;
      wr(sst_pkg::EXPANSION_MODE_OFF, 8'((a8 << 4) | k));
      b = ('h1fee >> k) & 1;
      `CHK(o_clock_source, b ? 2'h3 : (k == 4 ? 2'h2 : 2'h1))
      `CHK(o_avg_code, b ? 4'(k) : 4'h0)
      `CHK(o_base_divider, (b ? ('h0c8c >> k) & 1 : a8) ? 5'h08 : 5'h10)
    end
    rd(sst_pkg::EXPANSION_MODE_OFF);
    `CHK(got, 8'((a8 << 4) | 15))
    wr(sst_pkg::SERIAL_MODE_OFF, 8'h80);
    `CHK({o_sync_mode, o_clock_source}, 3'h5)
    wr(sst_pkg::SERIAL_CONTROL_OFF, 8'h00);
    `CHK(o_clock_source, 2'h0)
    rd(28'h0fff60f);
    `CHK(got, 8'h00)
    $display("test clock selection done");
    wrap_up();
  end
endmodule
